// ### hw/tfe_rx_framer_events.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module tfe_rx_framer_events #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // received line stream
  input wire tfe_pkg::tfe_line_t line,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt request
  output logic irq
);

  localparam int IDX_TOP = 10;

  // address must reach every register index
  if (ADDR_W < IDX_TOP) begin : g_bad_addr
    $error("ADDR_W too small for the register map");
  end

  tfe_pkg::tfe_state_t st;
  tfe_pkg::tfe_state_t n;

  logic lock;
  logic act;
  logic fbit;
  logic ferr;
  logic mf_end;
  logic win_start;
  logic [7:0] pos;
  logic [6:0] frm;
  logic [5:0] slc_n;
  logic [1:0] expv;
  logic [1:0] cnt;
  logic [5:0] crc_in;
  logic [5:0] crc_c;
  logic [8:0] rd;
  logic wr_go;
  logic [4:0] set1;
  logic [4:0] clr1;
  logic [3:0] setc;
  logic [3:0] clrc;
  logic set0;
  logic clr0;

  // expected framing bit: {checked, value}
  function automatic logic [1:0] f_expect(tfe_pkg::tfe_format_t f, logic [6:0] i);
    logic [5:0] nn;
    nn = 6'(i[6:1]) + 6'h01;
    f_expect = 2'h0;
    case (f)
      tfe_pkg::FMT_SF, tfe_pkg::FMT_DM: begin
        // ft alternates 1,0 on odd frames; fs follows its own pattern
        f_expect = {1'b1, i[0] ? tfe_pkg::SF_FS_PAT[i[3:1]] : ~i[1]};
      end
      tfe_pkg::FMT_ESF: begin
        if (i[1:0] == 2'h3) begin
          f_expect = {1'b1, tfe_pkg::ESF_FAS_PAT[i[4:2]]};
        end
      end
      tfe_pkg::FMT_SLC: begin
        if (!i[0]) begin
          f_expect = {1'b1, ~i[1]};
        end else if (nn <= tfe_pkg::SLC_N_SYNC_LAST) begin
          f_expect = {1'b1, tfe_pkg::SLC_FS_PAT[4'(nn - 6'h01)]};
        end else if (nn == tfe_pkg::SLC_N_END) begin
          f_expect = {1'b1, tfe_pkg::SLC_FS_PAT[tfe_pkg::SLC_FS_LAST]};
        end
      end
      default: f_expect = 2'h0;
    endcase
  endfunction

  // last frame index of the multiframe
  function automatic logic [6:0] f_mf_last(tfe_pkg::tfe_format_t f);
    case (f)
      tfe_pkg::FMT_ESF: f_mf_last = tfe_pkg::MF_LAST_ESF;
      tfe_pkg::FMT_SLC: f_mf_last = tfe_pkg::MF_LAST_SLC;
      default: f_mf_last = tfe_pkg::MF_LAST_SF;
    endcase
  endfunction

  // one serial step of crc-6, x^6 + x + 1
  function automatic logic [5:0] f_crc(logic [5:0] c, logic b);
    f_crc = {c[4:0], 1'b0} ^ ((c[5] ^ b) ? tfe_pkg::CRC_POLY : 6'h00);
  endfunction

  // register read decode: {hit, data}
  function automatic logic [8:0] f_rd(tfe_pkg::tfe_state_t s, logic [7:0] idx);
    case (idx)
      tfe_pkg::IDX_STATUS: f_rd = {1'b1, 7'h00, s.oof_status};
      tfe_pkg::IDX_INT_CTRL0: f_rd = {1'b1, 7'h00, s.oof_int_enable};
      tfe_pkg::IDX_INT_CTRL1: f_rd = {1'b1, 3'h0, s.framer_int_enable};
      tfe_pkg::IDX_EVENT0: f_rd = {1'b1, 7'h00, s.oof_flag};
      tfe_pkg::IDX_EVENT1: f_rd = {1'b1, 3'h0, s.ev1};
      tfe_pkg::IDX_CONC_LOW: f_rd = {1'b1, s.conc[7:0]};
      tfe_pkg::IDX_MAINT_CONC_HIGH: f_rd = {1'b1, 2'h0, s.maint, s.conc[10:8]};
      tfe_pkg::IDX_SWITCH_ALARM: f_rd = {1'b1, 2'h0, s.sw, s.alarm};
      tfe_pkg::IDX_OVH_CTRL: f_rd = {1'b1, 3'h0, s.ovh_ctrl};
      tfe_pkg::IDX_OVH_FLAGS: f_rd = {1'b1, 4'h0, s.chg};
      tfe_pkg::IDX_FORMAT: f_rd = {1'b1, 6'h00, s.format};
      default: f_rd = 9'h000;
    endcase
  endfunction

  // a field latches when debounce is off or it repeats
  function automatic logic f_take(logic deb, logic [10:0] cap, logic [10:0] prev);
    f_take = !deb || (cap == prev);
  endfunction

  // handshake outputs
  assign s_axi_awready = !st.aw_held && !st.bvalid;
  assign s_axi_wready = !st.w_held && !st.bvalid;
  assign s_axi_arready = !st.rvalid;

  // data outputs straight from state
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = {24'h000000, st.rdata};
  assign irq = st.irq;

  // next state of the whole block
  always_comb begin
    n = st;
    set1 = 5'h00;
    setc = 4'h0;
    cnt = 2'h0;
    crc_c = 6'h00;
    rd = 9'h000;
    lock = line.lock && line.bit_valid && line.in_sync;
    act = line.bit_valid && line.in_sync && (lock || st.trk != tfe_pkg::TRK_IDLE);
    pos = lock ? 8'h00 : st.bit_pos;
    frm = lock ? 7'h00 : st.frame_idx;
    slc_n = 6'(frm[6:1]) + 6'h01;
    expv = f_expect(st.format, frm);
    fbit = act && (pos == 8'h00);
    ferr = fbit && expv[1] && (line.bit_data != expv[0]);
    mf_end = act && (pos == tfe_pkg::FRAME_LAST) && (frm == f_mf_last(st.format));
    win_start = fbit && (st.format == tfe_pkg::FMT_ESF ? frm == 7'h00 :
                         (frm == 7'h00 || frm == tfe_pkg::SEVERE_WIN));
    crc_in = lock ? 6'h00 : st.crc;

    // status follows sync; any toggle raises the change flag
    n.oof_status = !line.in_sync;
    set0 = (st.oof_status != !line.in_sync);
    if (!line.in_sync) begin
      n.trk = tfe_pkg::TRK_IDLE;
    end

    // free-running bit phase, compared at each lock after the first
    if (line.bit_valid) begin
      n.phase = (st.phase == tfe_pkg::FRAME_LAST) ? 8'h00 : st.phase + 8'h01;
    end
    if (lock) begin
      set1[tfe_pkg::EV_ALIGN] = st.have_pos && (st.phase != st.held_phase);
      n.held_phase = st.phase;
      n.have_pos = 1'b1;
      n.trk = tfe_pkg::TRK_ALIGN;
      n.crc_prev_ok = 1'b0;
    end

    // per-bit framing work while aligned
    if (act) begin
      n.bit_pos = (pos == tfe_pkg::FRAME_LAST) ? 8'h00 : pos + 8'h01;
      if (pos == tfe_pkg::FRAME_LAST) begin
        n.frame_idx = (frm == f_mf_last(st.format)) ? 7'h00 : frm + 7'h01;
      end
      set1[tfe_pkg::EV_START] = fbit;
      set1[tfe_pkg::EV_FERR] = ferr;
      // severe count: ft errors per six frames, fas errors per esf multiframe
      cnt = win_start ? 2'h0 : st.err_cnt;
      if (ferr && st.format != tfe_pkg::FMT_SLC && (st.format == tfe_pkg::FMT_ESF || !frm[0])) begin
        set1[tfe_pkg::EV_SEVERE] = (cnt == 2'h1);
        n.err_cnt = (cnt == 2'h3) ? cnt : cnt + 2'h1;
      end else begin
        n.err_cnt = cnt;
      end
      // crc-6 over the multiframe with framing bits taken as one
      if (st.format == tfe_pkg::FMT_ESF) begin
        crc_c = f_crc(crc_in, fbit ? 1'b1 : line.bit_data);
        n.crc = crc_c;
        if (fbit && frm[1:0] == 2'h1) begin
          n.rx_crc = {st.rx_crc[4:0], line.bit_data};
        end
        if (mf_end) begin
          set1[tfe_pkg::EV_CRC] = st.crc_prev_ok && (st.crc_prev != st.rx_crc);
          n.crc_prev = crc_c;
          n.crc_prev_ok = 1'b1;
          n.crc = 6'h00;
        end
      end
      // slc-96 overhead capture from signaling bits
      if (st.format == tfe_pkg::FMT_SLC && fbit && frm[0]) begin
        if (slc_n >= tfe_pkg::SLC_C_N0 && slc_n < tfe_pkg::SLC_C_N0 + tfe_pkg::SLC_C_W) begin
          n.cap_c[4'(slc_n - tfe_pkg::SLC_C_N0)] = line.bit_data;
        end
        if (slc_n >= tfe_pkg::SLC_M_N0 && slc_n < tfe_pkg::SLC_M_N0 + tfe_pkg::SLC_M_W) begin
          n.cap_m[2'(slc_n - tfe_pkg::SLC_M_N0)] = line.bit_data;
        end
        if (slc_n >= tfe_pkg::SLC_A_N0 && slc_n < tfe_pkg::SLC_A_N0 + tfe_pkg::SLC_A_W) begin
          n.cap_a[1'(slc_n - tfe_pkg::SLC_A_N0)] = line.bit_data;
        end
        if (slc_n >= tfe_pkg::SLC_S_N0 && slc_n < tfe_pkg::SLC_S_N0 + tfe_pkg::SLC_S_W) begin
          n.cap_s[2'(slc_n - tfe_pkg::SLC_S_N0)] = line.bit_data;
        end
      end
      // latch at superframe end, only while in sync
      if (st.format == tfe_pkg::FMT_SLC && mf_end) begin
        if (f_take(st.ovh_ctrl[tfe_pkg::OVH_DEBOUNCE], st.cap_c, st.prev_c)) begin
          n.conc = st.cap_c;
          setc[tfe_pkg::CHG_CONC] = (st.cap_c != st.conc);
        end
        if (f_take(st.ovh_ctrl[tfe_pkg::OVH_DEBOUNCE], 11'(st.cap_m), 11'(st.prev_m))) begin
          n.maint = st.cap_m;
          setc[tfe_pkg::CHG_MAINT] = (st.cap_m != st.maint);
        end
        if (f_take(st.ovh_ctrl[tfe_pkg::OVH_DEBOUNCE], 11'(st.cap_s), 11'(st.prev_s))) begin
          n.sw = st.cap_s;
          setc[tfe_pkg::CHG_SWITCH] = (st.cap_s != st.sw);
        end
        if (f_take(st.ovh_ctrl[tfe_pkg::OVH_DEBOUNCE], 11'(st.cap_a), 11'(st.prev_a))) begin
          n.alarm = st.cap_a;
          setc[tfe_pkg::CHG_ALARM] = (st.cap_a != st.alarm);
        end
        n.prev_c = st.cap_c;
        n.prev_m = st.cap_m;
        n.prev_s = st.cap_s;
        n.prev_a = st.cap_a;
      end
      if (mf_end) begin
        n.trk = tfe_pkg::TRK_RUN;
      end
    end

    // axi write: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_held = 1'b1;
      n.aw_idx = s_axi_awaddr[IDX_TOP-1:2];
      n.aw_oor = (s_axi_awaddr >> IDX_TOP) != '0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_held = 1'b1;
      n.wdata = s_axi_wdata[7:0];
      n.wstrb0 = s_axi_wstrb[0];
    end
    wr_go = st.aw_held && st.w_held && !st.bvalid;
    rd = f_rd(st, st.aw_idx);
    clr0 = 1'b0;
    clr1 = 5'h00;
    clrc = 4'h0;
    if (wr_go) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (rd[8] && !st.aw_oor) ? tfe_pkg::RESP_OKAY : tfe_pkg::RESP_SLVERR;
      if (st.wstrb0 && !st.aw_oor) begin
        case (st.aw_idx)
          tfe_pkg::IDX_INT_CTRL0: n.oof_int_enable = st.wdata[0];
          tfe_pkg::IDX_INT_CTRL1: n.framer_int_enable = st.wdata[4:0];
          tfe_pkg::IDX_EVENT0: clr0 = st.wdata[0];
          tfe_pkg::IDX_EVENT1: clr1 = st.wdata[4:0];
          tfe_pkg::IDX_OVH_CTRL: n.ovh_ctrl = st.wdata[4:0];
          tfe_pkg::IDX_OVH_FLAGS: clrc = st.wdata[3:0];
          tfe_pkg::IDX_FORMAT: n.format = tfe_pkg::tfe_format_t'(st.wdata[1:0]);
          default: ;
        endcase
      end
    end else if (st.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // axi read: one word answered the cycle after acceptance
    if (s_axi_arvalid && s_axi_arready) begin
      rd = f_rd(st, s_axi_araddr[IDX_TOP-1:2]);
      n.rvalid = 1'b1;
      if (rd[8] && (s_axi_araddr >> IDX_TOP) == '0) begin
        n.rdata = rd[7:0];
        n.rresp = tfe_pkg::RESP_OKAY;
      end else begin
        n.rdata = 8'h00;
        n.rresp = tfe_pkg::RESP_SLVERR;
      end
    end else if (st.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end

    // sticky flags: a set in the clearing cycle wins
    n.oof_flag = (st.oof_flag && !clr0) || set0;
    n.ev1 = (st.ev1 & ~clr1) | set1;
    n.chg = (st.chg & ~clrc) | setc;

    // interrupt request from flags and enables
    n.irq = (st.oof_flag && st.oof_int_enable) || |(st.ev1 & st.framer_int_enable) ||
            |(st.chg & st.ovh_ctrl[3:0]);
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
      st.oof_status <= tfe_pkg::STATUS_RST;
    end else begin
      st <= n;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_sync_toggle;
    $changed(st.oof_status);
  endsequence

  sequence s_frame_bit;
    act && (pos == 8'h00);
  endsequence

  AST_OOF_CHANGE: assert property (s_sync_toggle |-> st.oof_flag)
    else $error("frame loss change flag missed a toggle");
  AST_W1C_HOLD: assert property (st.ev1[tfe_pkg::EV_FERR] && !wr_go |=>
      st.ev1[tfe_pkg::EV_FERR])
    else $error("event flag dropped without a write");
  AST_FRAME_START: assert property (s_frame_bit |=> st.ev1[tfe_pkg::EV_START])
    else $error("frame start flag not set at first bit");
  AST_NO_START_OOS: assert property (!line.in_sync && !st.ev1[tfe_pkg::EV_START] |=>
      !st.ev1[tfe_pkg::EV_START])
    else $error("frame start flag set while out of sync");
  AST_HOLD_OOS: assert property (!line.in_sync |=> $stable(st.conc) && $stable(st.alarm))
    else $error("overhead latch moved out of sync");
  AST_CHG_MAINT: assert property ($changed(st.maint) |-> st.chg[tfe_pkg::CHG_MAINT])
    else $error("maintenance change flag not set");
  AST_IRQ: assert property ((st.ev1[tfe_pkg::EV_CRC] && st.framer_int_enable[tfe_pkg::EV_CRC])
      ##1 st.ev1[tfe_pkg::EV_CRC] |-> irq)
    else $error("interrupt missing for enabled flag");
  AST_IRQ_ALARM: assert property (!st.chg[tfe_pkg::CHG_ALARM] && !st.oof_flag && st.ev1 == 5'h00
      && st.chg == 4'h0 |=> !irq)
    else $error("interrupt without any flag");
  AST_DEB_RESET: assert property (@(posedge clk) disable iff (1'b0)
      srst |=> st.ovh_ctrl[tfe_pkg::OVH_DEBOUNCE] == 1'b0)
    else $error("debounce not off after reset");
  AST_ALIGN: assert property (lock && st.have_pos && st.phase != st.held_phase |=>
      st.ev1[tfe_pkg::EV_ALIGN])
    else $error("alignment change not flagged");
  AST_WRITE_RESP: assert property (wr_go |=> st.bvalid ##0 s_axi_bvalid [*1])
    else $error("write response missing");

endmodule // tfe_rx_framer_events

`default_nettype wire

// ### hw/tfe_pkg.sv
package tfe_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h4f;
  localparam logic [7:0] IDX_INT_CTRL0 = 8'h50;
  localparam logic [7:0] IDX_INT_CTRL1 = 8'h51;
  localparam logic [7:0] IDX_EVENT0 = 8'h52;
  localparam logic [7:0] IDX_EVENT1 = 8'h53;
  localparam logic [7:0] IDX_CONC_LOW = 8'h56;
  localparam logic [7:0] IDX_MAINT_CONC_HIGH = 8'h57;
  localparam logic [7:0] IDX_SWITCH_ALARM = 8'h58;
  localparam logic [7:0] IDX_OVH_CTRL = 8'h5c;
  localparam logic [7:0] IDX_OVH_FLAGS = 8'h5d;
  localparam logic [7:0] IDX_FORMAT = 8'h60;

  // field positions
  localparam int EV_START = 4;
  localparam int EV_SEVERE = 3;
  localparam int EV_CRC = 2;
  localparam int EV_FERR = 1;
  localparam int EV_ALIGN = 0;
  localparam int CHG_ALARM = 3;
  localparam int CHG_SWITCH = 2;
  localparam int CHG_MAINT = 1;
  localparam int CHG_CONC = 0;
  localparam int OVH_DEBOUNCE = 4;

  // reset values
  localparam logic STATUS_RST = 1'b1;

  // line framing figures
  localparam logic [7:0] FRAME_LAST = 8'hc0;
  localparam logic [6:0] MF_LAST_SF = 7'h0b;
  localparam logic [6:0] MF_LAST_ESF = 7'h17;
  localparam logic [6:0] MF_LAST_SLC = 7'h47;
  localparam logic [6:0] SEVERE_WIN = 7'h06;
  localparam logic [5:0] SF_FS_PAT = 6'h1c;
  localparam logic [5:0] ESF_FAS_PAT = 6'h34;
  localparam logic [11:0] SLC_FS_PAT = 12'he38;
  localparam logic [3:0] SLC_FS_LAST = 4'hb;
  localparam logic [5:0] CRC_POLY = 6'h03;

  // slc-96 signaling frame numbers (frame 2n)
  localparam logic [5:0] SLC_N_SYNC_LAST = 6'h0b;
  localparam logic [5:0] SLC_N_END = 6'h24;
  localparam logic [5:0] SLC_C_N0 = 6'h0c;
  localparam logic [5:0] SLC_M_N0 = 6'h1a;
  localparam logic [5:0] SLC_A_N0 = 6'h1d;
  localparam logic [5:0] SLC_S_N0 = 6'h1f;
  localparam logic [5:0] SLC_C_W = 6'h0b;
  localparam logic [5:0] SLC_M_W = 6'h03;
  localparam logic [5:0] SLC_A_W = 6'h02;
  localparam logic [5:0] SLC_S_W = 6'h04;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {FMT_SF = 2'h0, FMT_ESF = 2'h1, FMT_DM = 2'h2, FMT_SLC = 2'h3}
    tfe_format_t;

  // gray along idle -> align -> run
  typedef enum logic [1:0] {TRK_IDLE = 2'h0, TRK_ALIGN = 2'h1, TRK_RUN = 2'h3} tfe_trk_t;

  // received bit stream from the frame search logic
  typedef struct packed {
    logic bit_valid;
    logic bit_data;
    logic in_sync;
    logic lock;
  } tfe_line_t;

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_idx;
    logic aw_oor;
    logic w_held;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    tfe_format_t format;
    logic oof_int_enable;
    logic [4:0] framer_int_enable;
    logic [4:0] ovh_ctrl;
    logic oof_status;
    logic oof_flag;
    logic [4:0] ev1;
    logic [3:0] chg;
    logic [10:0] conc;
    logic [2:0] maint;
    logic [3:0] sw;
    logic [1:0] alarm;
    tfe_trk_t trk;
    logic [7:0] bit_pos;
    logic [6:0] frame_idx;
    logic [7:0] phase;
    logic [7:0] held_phase;
    logic have_pos;
    logic [1:0] err_cnt;
    logic [5:0] crc;
    logic [5:0] crc_prev;
    logic crc_prev_ok;
    logic [5:0] rx_crc;
    logic [10:0] cap_c;
    logic [2:0] cap_m;
    logic [3:0] cap_s;
    logic [1:0] cap_a;
    logic [10:0] prev_c;
    logic [2:0] prev_m;
    logic [3:0] prev_s;
    logic [1:0] prev_a;
    logic irq;
  } tfe_state_t;

endpackage

// ### sim/tfe_line_model.sv
`timescale 1ns/1ps
`default_nettype none

module tfe_line_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // run control
  input wire logic go,
  input wire logic sync,
  input wire logic [71:0] fpat,
  input wire logic [71:0] flips,
  input wire logic [6:0] flast,
  input wire logic [7:0] lead,
  // line side
  output var tfe_pkg::tfe_line_t line,
  output logic busy
);
  logic [7:0] bitc;
  logic [6:0] frm;
  logic [7:0] ld;

  // one bit a cycle while busy; idle data toggles so it never looks held
  always_ff @(posedge clk) begin
    if (srst) begin
      line <= '0;
      busy <= 1'b0;
    end else begin
      line.in_sync <= sync;
      line.bit_valid <= busy;
      line.lock <= busy && ld == 8'h00 && bitc == 8'h00 && frm == 7'h00;
      line.bit_data <= ~line.bit_data;
      if (!busy) begin
        busy <= go;
        ld <= lead;
        bitc <= 8'h00;
        frm <= 7'h00;
      end else if (ld != 8'h00) begin
        ld <= ld - 8'h01; // slip bits ahead of the lock bit
      end else begin
        line.bit_data <= (bitc == 8'h00) ? (fpat[frm] ^ flips[frm]) : bitc[0];
        bitc <= (bitc == tfe_pkg::FRAME_LAST) ? 8'h00 : bitc + 8'h01;
        if (bitc == tfe_pkg::FRAME_LAST) frm <= frm + 7'h01;
        if (bitc == tfe_pkg::FRAME_LAST && frm == flast) busy <= 1'b0;
      end
    end
  end
endmodule // tfe_line_model

`default_nettype wire

// ### sim/t1_rx_frame_events_slc_overhead_bench.sv
`timescale 1ns/1ps
`default_nettype none

module t1_rx_frame_events_slc_overhead_bench;
  localparam logic [1:0] OK = tfe_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = tfe_pkg::RESP_SLVERR;
  localparam tfe_pkg::tfe_format_t FMTS [3] = '{tfe_pkg::FMT_SF, tfe_pkg::FMT_DM, tfe_pkg::FMT_ESF};
  // f bits by frame, bit 0 is frame 1; two framing errors per format
  localparam logic [23:0] PATS [3] = '{24'h3b13b1, 24'h3b13b1, 24'h880800};
  localparam logic [23:0] FLIPS [3] = '{24'h000014, 24'h000014, 24'h000088};
  // slc-96 f bits, frames 1..72: c=007, m=5, a=2, s=3
  localparam logic [71:0] SLC_PAT = 72'h91b99911111bb91b91;
  // rows: write, index, write data, expected read, expected response
  localparam logic [26:0] ROWS [18] = '{
    {1'b0, 8'h4f, 8'h00, 8'h01, OK}, {1'b0, 8'h50, 8'h00, 8'h00, OK},
    {1'b0, 8'h51, 8'h00, 8'h00, OK}, {1'b0, 8'h52, 8'h00, 8'h00, OK},
    {1'b0, 8'h53, 8'h00, 8'h00, OK}, {1'b0, 8'h56, 8'h00, 8'h00, OK},
    {1'b0, 8'h57, 8'h00, 8'h00, OK}, {1'b0, 8'h58, 8'h00, 8'h00, OK},
    {1'b0, 8'h5c, 8'h00, 8'h00, OK}, {1'b0, 8'h5d, 8'h00, 8'h00, OK},
    {1'b0, 8'h60, 8'h00, 8'h00, OK}, {1'b0, 8'h70, 8'h00, 8'h00, ERR},
    {1'b1, 8'h70, 8'hff, 8'h00, ERR}, {1'b1, 8'h5c, 8'h1f, 8'h00, OK},
    {1'b0, 8'h5c, 8'h00, 8'h1f, OK}, {1'b1, 8'h5c, 8'h00, 8'h00, OK},
    {1'b1, 8'h51, 8'h1f, 8'h00, OK}, {1'b0, 8'h51, 8'h00, 8'h1f, OK}};

  logic clk = 1'b0;
  logic srst = 1'b1;
  tfe_pkg::tfe_line_t line;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic go = 1'b0, sync = 1'b0;
  logic [71:0] fpat = 72'h0, flips = 72'h0;
  logic [6:0] flast = 7'h00;
  logic [7:0] lead = 8'h0;
  int err_count = 0;
  int samples_checked = 0;

  // 40 mhz clock
  always #12.5 clk = ~clk;

  tfe_rx_framer_events #(.ADDR_W(12)) DUT (
    .clk(clk), .srst(srst), .line(line),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq));

  tfe_line_model line_src (
    .clk(clk), .srst(srst), .go(go), .sync(sync), .fpat(fpat), .flips(flips),
    .flast(flast), .lead(lead), .line(line), .busy(busy));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // readiness is sampled mid-cycle, acted on at the next rising edge
  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic done, aw_t, w_t;
    done = 1'b0;
    @(posedge clk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      aw_t = awready;
      w_t = wready;
      if (bvalid) begin
        check("bresp", {30'h0, bresp}, {30'h0, er});
        done = 1'b1;
      end
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er,
                        input logic [7:0] m);
    logic done, ar_t;
    done = 1'b0;
    @(posedge clk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      ar_t = arready;
      if (rvalid) begin
        check("rdata", rdata & {24'hffffff, m}, {24'h0, e & m});
        check("rresp", {30'h0, rresp}, {30'h0, er});
        done = 1'b1;
      end
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
  endtask

  // one line run of fl+1 frames, then let flags and irq settle
  task automatic run(input logic [71:0] p, input logic [71:0] f, input logic [6:0] fl,
                     input logic [7:0] ld);
    int n;
    n = 0;
    @(posedge clk);
    fpat <= p;
    flips <= f;
    flast <= fl;
    lead <= ld;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    while (busy && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (busy) err_count++;
    repeat (3) @(posedge clk);
  endtask

  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("irq", {31'h0, irq}, {31'h0, e});
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    foreach (ROWS[i]) begin
      if (ROWS[i][26]) axi_wr(ROWS[i][25:18], ROWS[i][17:10], ROWS[i][1:0]);
      else axi_rd(ROWS[i][25:18], ROWS[i][9:2], ROWS[i][1:0], 8'hff);
    end
    // framing events in sf, dm and esf, then write-one-to-clear
    sync <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      axi_wr(8'h60, {6'h0, FMTS[k]}, OK);
      run(72'(PATS[k]), 72'(FLIPS[k]), 7'h17, 8'h00);
      axi_rd(8'h53, 8'h1a, OK, 8'h1e);
      irq_is(1'b1);
      axi_wr(8'h53, 8'h00, OK);
      axi_rd(8'h53, 8'h1a, OK, 8'h1e);
      axi_wr(8'h53, 8'h02, OK);
      axi_rd(8'h53, 8'h18, OK, 8'h1e);
      axi_wr(8'h53, 8'h1f, OK);
    end
    axi_rd(8'h53, 8'h00, OK, 8'hff);
    axi_rd(8'h4f, 8'h00, OK, 8'hff);
    axi_rd(8'h52, 8'h01, OK, 8'hff);
    irq_is(1'b0);
    axi_wr(8'h50, 8'h01, OK);
    irq_is(1'b1);
    axi_wr(8'h52, 8'h01, OK);
    irq_is(1'b0);
    // out of sync: status back to one, frame start frozen
    sync <= 1'b0;
    run(72'(PATS[0]), 72'h0, 7'h17, 8'h00);
    axi_rd(8'h4f, 8'h01, OK, 8'hff);
    axi_rd(8'h52, 8'h01, OK, 8'hff);
    axi_rd(8'h53, 8'h00, OK, 8'hff);
    // relock five bits later: new alignment, no framing error
    sync <= 1'b1;
    axi_wr(8'h60, 8'h00, OK);
    run(72'(PATS[0]), 72'h0, 7'h17, 8'h05);
    axi_rd(8'h53, 8'h11, OK, 8'h1f);
    // slc-96 superframe: overhead latched once, every change flag set
    axi_wr(8'h53, 8'h1f, OK);
    axi_wr(8'h60, 8'h03, OK);
    run(SLC_PAT, 72'h0, 7'h47, 8'h00);
    axi_rd(8'h53, 8'h10, OK, 8'h1f);
    axi_rd(8'h56, 8'h07, OK, 8'hff);
    axi_rd(8'h57, 8'h28, OK, 8'hff);
    axi_rd(8'h58, 8'h0e, OK, 8'hff);
    axi_rd(8'h5d, 8'h0f, OK, 8'hff);
    // reset after the last run: defaults return, no false change flag after release
    sync <= 1'b0;
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    axi_rd(8'h4f, 8'h01, OK, 8'hff);
    axi_rd(8'h52, 8'h00, OK, 8'hff);
    axi_rd(8'h51, 8'h00, OK, 8'hff);
    axi_rd(8'h58, 8'h00, OK, 8'hff);
    axi_rd(8'h5d, 8'h00, OK, 8'hff);
    give_verdict();
  end

  // watchdog well past the expected run length
  initial begin
    repeat (80000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule // t1_rx_frame_events_slc_overhead_bench

`default_nettype wire
